// ---- bench/iopll_asserts.sv ----
`include "iopll_cfg.svh"

module iopll_chk (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic [7:0] o_rdata,
  input wire logic o_osc_in,
  input wire logic o_osc_in_oe,
  input wire logic o_osc_out,
  input wire logic o_osc_out_oe,
  input wire logic o_pll_active,
  input wire logic [15:0] o_sys_khz,
  input wire logic [5:0] o_hf_trim,
  input wire logic [5:0] o_mf_trim,
  input wire logic [5:0] o_lf_trim
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic io_q; // shadow of pin mode, 1 = io
  logic [2:0] cm_q; // cycles in clkout mode, saturating
  logic wt, wo, wp; // write strobes per register
  assign wt = i_wr && i_addr == `IOPLL_ADDR_TUNE;
  assign wo = i_wr && i_addr == `IOPLL_ADDR_OSCCTL;
  assign wp = i_wr && i_addr == `IOPLL_ADDR_PINCTL;
  // follow the pin mode as software sets it
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      io_q <= 1'b0;
    end else if (wp) begin
      io_q <= i_wdata[4];
    end
  end
  // divider needs a few cycles after a mode change before its wave is judged
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cm_q <= 3'h0;
    end else if (io_q) begin
      cm_q <= 3'h0;
    end else if (cm_q != 3'h7) begin
      cm_q <= cm_q + 3'h1;
    end
  end
  sequence s_hi;
    o_osc_out [*2];
  endsequence
  sequence s_lo;
    !o_osc_out [*2];
  endsequence
  // leaving clkout mode ends the wave legally, so it disables the check
  property p_wave;
    disable iff (!i_rst_b || io_q)
    cm_q == 3'h7 && $rose(o_osc_out) |-> s_hi ##1 s_lo ##1 o_osc_out;
  endproperty
  chk_lf_fixed: assert property (o_lf_trim == 6'h00)
    else $error("low osc trim moved");
  chk_mf_follows: assert property (o_mf_trim == o_hf_trim)
    else $error("mid osc trim differs");
  chk_trim_gap: assert property ($changed(o_hf_trim) |=> $stable(o_hf_trim) [*8])
    else $error("trim stepped too fast");
  chk_trim_unit: assert property ($changed(o_hf_trim) |->
    6'(o_hf_trim - $past(o_hf_trim)) inside {6'h01, 6'h3F})
    else $error("trim step not one code");
  chk_pll_off: assert property (wt && !i_wdata[6] |-> ##3 !o_pll_active)
    else $error("multiplier on while disabled");
  chk_fsel_gate: assert property (wo && i_wdata[6:5] != 2'b11 |-> ##3 !o_pll_active)
    else $error("multiplier on at low select");
  chk_pll_rate: assert property (o_pll_active |-> o_sys_khz inside {16'h7D00, 16'hFA00})
    else $error("multiplied rate wrong");
  chk_base_rate: assert property (!o_pll_active |-> o_sys_khz <= 16'h3E80)
    else $error("unmultiplied rate too high");
  chk_clkout_oe: assert property (cm_q == 3'h7 |-> o_osc_out_oe)
    else $error("clock pin not driven");
  chk_clkout_wave: assert property (p_wave)
    else $error("clock pin wave wrong");
  chk_io_pins: assert property (wp && i_wdata[4] |-> ##3
    (o_osc_out == $past(i_wdata[0], 3) && o_osc_out_oe == $past(i_wdata[2], 3)))
    else $error("io mode pin wrong");
  chk_in_pin: assert property (wp |-> ##3
    (o_osc_in == $past(i_wdata[1], 3) && o_osc_in_oe == $past(i_wdata[3], 3)))
    else $error("port bit 7 pin wrong");
endmodule

bind iopll_top iopll_chk u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_rdata(o_rdata), .o_osc_in(o_osc_in),
  .o_osc_in_oe(o_osc_in_oe), .o_osc_out(o_osc_out), .o_osc_out_oe(o_osc_out_oe),
  .o_pll_active(o_pll_active), .o_sys_khz(o_sys_khz), .o_hf_trim(o_hf_trim),
  .o_mf_trim(o_mf_trim), .o_lf_trim(o_lf_trim));

// ---- bench/iopll_bench.sv ----
`include "iopll_cfg.svh"

module iopll_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_osc_in = 1'b1; // pin levels seen by status
  logic i_osc_out = 1'b0;
  logic [7:0] o_rdata;
  logic o_osc_in, o_osc_in_oe, o_osc_out, o_osc_out_oe, o_pll_active;
  logic [15:0] o_sys_khz;
  logic [5:0] o_hf_trim, o_mf_trim, o_lf_trim;
  int num_errors = 0;
  int tests_run = 0;
  int n; // cycles since a trim write
  logic [7:0] rv; // last read value
  logic [7:0] w; // sampled clock pin wave
  // base rate per select code, kHz
  logic [15:0] khz [8] = '{16'h001F, 16'h00FA, 16'h01F4, 16'h03E8,
    16'h07D0, 16'h0FA0, 16'h1F40, 16'h3E80};
  logic [7:0] pv [4] = '{8'h15, 8'h1A, 8'h1F, 8'h10}; // io mode pin patterns

  always #20 i_mclk = ~i_mclk;

  iopll_top uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_in(i_osc_in), .o_osc_in(o_osc_in),
    .o_osc_in_oe(o_osc_in_oe), .i_osc_out(i_osc_out), .o_osc_out(o_osc_out),
    .o_osc_out_oe(o_osc_out_oe), .o_pll_active(o_pll_active), .o_sys_khz(o_sys_khz),
    .o_hf_trim(o_hf_trim), .o_mf_trim(o_mf_trim), .o_lf_trim(o_lf_trim));

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // data only stands in the cycle after the strobe, so grab it there
  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  // outputs lag a write by two edges; one more for margin
  task automatic wt3();
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    cmp("sys_khz", 16'h1F40, o_sys_khz);
    cmp("hf_trim", 16'h0000, 16'(o_hf_trim));
    rd(`IOPLL_ADDR_TUNE);
    cmp("tune_reg", 16'h0000, 16'(rv));
    rd(`IOPLL_ADDR_OSCCTL);
    cmp("osc_ctl", 16'h0060, 16'(rv));
    // read data must fall back to zero one cycle after it stood
    @(posedge i_mclk);
    #1 cmp("rdata_gap", 16'h0000, 16'(o_rdata));
    $display("test reset done");
    // every select code, multiplier off then on
    for (int p = 0; p < 2; p++) begin
      wr(`IOPLL_ADDR_TUNE, p ? 8'h40 : 8'h00);
      for (int f = 0; f < 8; f++) begin
        wr(`IOPLL_ADDR_OSCCTL, 8'(f << 4));
        wt3();
        cmp("pll_active", 16'(p && f >= 6), 16'(o_pll_active));
        cmp("sys_khz", (p && f >= 6) ? khz[f] << 2 : khz[f], o_sys_khz);
      end
    end
    rd(`IOPLL_ADDR_STATUS);
    cmp("status", 16'h0005, 16'(rv));
    wr(`IOPLL_ADDR_STATUS, 8'h00);
    rd(`IOPLL_ADDR_STATUS);
    cmp("status_ro", 16'h0005, 16'(rv));
    rd(4'h9);
    cmp("unmapped", 16'h0000, 16'(rv));
    wr(`IOPLL_ADDR_TUNE, 8'h00);
    wt3();
    cmp("sys_khz", 16'h3E80, o_sys_khz);
    $display("test rate done");
    // clkout mode: port bit 7 usable while the other pin carries the clock
    wr(`IOPLL_ADDR_PINCTL, 8'h0A);
    wt3();
    w = 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_mclk);
      #1 w = {w[6:0], o_osc_out};
    end
    cmp("in_pin", 16'h0003, 16'({o_osc_in_oe, o_osc_in}));
    cmp("clkout_oe", 16'h0001, 16'(o_osc_out_oe));
    cmp("clkout_wave", 16'h0001,
      16'(w == 8'hCC || w == 8'h66 || w == 8'h33 || w == 8'h99));
    // io mode: both pins follow latch and enable
    for (int i = 0; i < 4; i++) begin
      wr(`IOPLL_ADDR_PINCTL, pv[i]);
      wt3();
      cmp("io_pins", 16'(pv[i][3:0]),
        16'({o_osc_in_oe, o_osc_out_oe, o_osc_in, o_osc_out}));
    end
    wr(`IOPLL_ADDR_PINCTL, 8'h00);
    $display("test pins done");
    // trim slews one code per step, no flag, low osc untouched
    wr(`IOPLL_ADDR_TUNE, 8'h03);
    rd(`IOPLL_ADDR_TUNE);
    cmp("tune_reg", 16'h0003, 16'(rv));
    n = 2;
    while (o_hf_trim !== 6'h03 && n < 200) begin
      @(posedge i_mclk);
      #1 n++;
    end
    cmp("trim_time", 16'h0001, 16'(n >= 51 && n <= 78));
    cmp("lf_trim", 16'h0000, 16'(o_lf_trim));
    wr(`IOPLL_ADDR_TUNE, 8'h01);
    n = 0;
    while (o_hf_trim !== 6'h01 && n < 100) begin
      @(posedge i_mclk);
      #1 n++;
    end
    cmp("trim_down", 16'h0001, 16'(o_mf_trim));
    $display("test trim done");
    test_done();
  end

  // cut a hang short
  initial begin
    repeat (5000) @(posedge i_mclk);
    num_errors++;
    $display("[ERR] watchdog expected end seen hang");
    test_done();
  end
endmodule

// ---- rtl/iopll_cfg.svh ----
`ifndef IOPLL_CFG_SVH
`define IOPLL_CFG_SVH

// register offsets on the plain register port
`define IOPLL_ADDR_TUNE 4'h0
`define IOPLL_ADDR_OSCCTL 4'h1
`define IOPLL_ADDR_PINCTL 4'h2
`define IOPLL_ADDR_STATUS 4'h3

// tuning register fields
`define IOPLL_TUNE_PLL_EN_BIT 6
`define IOPLL_TUNE_MSB 5
`define IOPLL_TUNE_LSB 0

// oscillator control fields
`define IOPLL_FSEL_MSB 6
`define IOPLL_FSEL_LSB 4

// pin control fields
`define IOPLL_PIN_LAT6_BIT 0
`define IOPLL_PIN_LAT7_BIT 1
`define IOPLL_PIN_OE6_BIT 2
`define IOPLL_PIN_OE7_BIT 3
`define IOPLL_PIN_MODE_BIT 4

// status fields
`define IOPLL_STAT_PLL_BIT 0
`define IOPLL_STAT_IN6_BIT 1
`define IOPLL_STAT_IN7_BIT 2

// reset values
`define IOPLL_TUNE_RST 8'h00
`define IOPLL_FSEL_RST 3'h6
`define IOPLL_PINCTL_RST 5'h00

// frequency select codes that allow the multiplier
`define IOPLL_FSEL_16M 3'h7
`define IOPLL_FSEL_8M 3'h6

// multiplier factor
`define IOPLL_PLL_MULT 4

// internal source frequencies in kHz
`define IOPLL_KHZ_16M 16'h3E80
`define IOPLL_KHZ_8M 16'h1F40
`define IOPLL_KHZ_4M 16'h0FA0
`define IOPLL_KHZ_2M 16'h07D0
`define IOPLL_KHZ_1M 16'h03E8
`define IOPLL_KHZ_500K 16'h01F4
`define IOPLL_KHZ_250K 16'h00FA
`define IOPLL_KHZ_31K 16'h001F

// timing: clock period and the trim slew step time, in ns
`define IOPLL_CLK_NS 40
`define IOPLL_STEP_NS 1000
`define IOPLL_STEP_CYC ((`IOPLL_STEP_NS + `IOPLL_CLK_NS - 1) / `IOPLL_CLK_NS)

// clock output divide ratio (device clock over four)
`define IOPLL_CLKOUT_DIV 4

`endif

// ---- rtl/iopll_clkdiv.sv ----
`include "iopll_cfg.svh"

module iopll_clkdiv (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  output logic o_clk_div
);

  // half-period counter; divide ratio is even
  localparam int HALF = `IOPLL_CLKOUT_DIV / 2;
  localparam logic [3:0] HALF_LAST = 4'(HALF - 1);

  logic [3:0] cnt_q;
  logic clk_q;

  // square wave, one full period every four device clocks
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 4'h0;
      clk_q <= 1'b0;
    end else if (cnt_q == HALF_LAST) begin
      cnt_q <= 4'h0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign o_clk_div = clk_q;

endmodule

// ---- rtl/iopll_pkg.sv ----
package iopll_pkg;

  // pin mode of the two oscillator pins
  typedef enum logic {
    IOPLL_CLKOUT_MODE,
    IOPLL_IO_MODE
  } iopll_pin_mode_t;

  // trim slewer states
  typedef enum logic [1:0] {
    IOPLL_SLEW_IDLE,
    IOPLL_SLEW_MOVE
  } iopll_slew_state_t;

  // internal frequency select code
  typedef logic [2:0] iopll_fsel_t;

  // tune field value
  typedef logic [5:0] iopll_tune_t;

endpackage

// ---- rtl/iopll_top.sv ----
// Operation
// - four-times multiplier on the high-frequency oscillator
// - multiplied system clock is 32 or 64 MHz
// - pll_enable_bit at bit 6 gates multiplier
// - multiplier only with frequency select 111/110
// - clkout mode: osc_out drives clock/4, osc_in I/O
// - io mode: both oscillator pins are port I/O
// - reset trim gives nominal 16 MHz output
// - tune_field bits 5:0 adjust the oscillator
// - trim slews silently while execution continues
// - low-frequency oscillator ignores tune_field
`include "iopll_cfg.svh"

module iopll_top (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // osc_in_pin, always port_a_bit7_pin
  input wire logic i_osc_in,
  output logic o_osc_in,
  output logic o_osc_in_oe,
  // osc_out_pin, clock out or port_a_bit6_pin
  input wire logic i_osc_out,
  output logic o_osc_out,
  output logic o_osc_out_oe,
  // clock source state
  output logic o_pll_active,
  output logic [15:0] o_sys_khz,
  output logic [5:0] o_hf_trim,
  output logic [5:0] o_mf_trim,
  output logic [5:0] o_lf_trim
);

  // register storage

  // pll_enable_bit
  logic pll_en_q;
  // tune_field as written
  iopll_pkg::iopll_tune_t tune_q;
  // internal frequency select
  iopll_pkg::iopll_fsel_t fsel_q;
  // port latches and drive enables
  logic lat6_q;
  logic lat7_q;
  logic oe6_q;
  logic oe7_q;
  // oscillator pin mode
  iopll_pkg::iopll_pin_mode_t mode_q;
  // read data register
  logic [7:0] rdata_q;

  // derived state
  logic pll_ok;
  logic [15:0] base_khz;
  logic [15:0] sys_khz_d;
  logic [15:0] sys_khz_q;
  logic pll_active_q;

  // pin output registers
  logic osc_out_q;
  logic osc_out_oe_q;
  logic osc_in_q;
  logic osc_in_oe_q;

  // divided clock from the divider
  logic clk_div;

  // trim path to the slewer
  iopll_trim_if trim ();

  // register writes

  // tuning register: enable bit and trim field
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pll_en_q <= 1'(`IOPLL_TUNE_RST >> `IOPLL_TUNE_PLL_EN_BIT);
      tune_q <= 6'(`IOPLL_TUNE_RST);
    end else if (i_wr && (i_addr == `IOPLL_ADDR_TUNE)) begin
      // software switches the multiplier on or off
      pll_en_q <= i_wdata[`IOPLL_TUNE_PLL_EN_BIT];
      tune_q <= i_wdata[`IOPLL_TUNE_MSB:`IOPLL_TUNE_LSB];
    end
  end

  // oscillator control: frequency select only
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fsel_q <= `IOPLL_FSEL_RST;
    end else if (i_wr && (i_addr == `IOPLL_ADDR_OSCCTL)) begin
      fsel_q <= i_wdata[`IOPLL_FSEL_MSB:`IOPLL_FSEL_LSB];
    end
  end

  // pin control register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lat6_q <= 1'b0;
      lat7_q <= 1'b0;
      oe6_q <= 1'b0;
      oe7_q <= 1'b0;
      mode_q <= iopll_pkg::IOPLL_CLKOUT_MODE;
    end else if (i_wr && (i_addr == `IOPLL_ADDR_PINCTL)) begin
      lat6_q <= i_wdata[`IOPLL_PIN_LAT6_BIT];
      lat7_q <= i_wdata[`IOPLL_PIN_LAT7_BIT];
      oe6_q <= i_wdata[`IOPLL_PIN_OE6_BIT];
      oe7_q <= i_wdata[`IOPLL_PIN_OE7_BIT];
      // bit set selects io mode, clear selects clkout mode
      if (i_wdata[`IOPLL_PIN_MODE_BIT]) begin
        mode_q <= iopll_pkg::IOPLL_IO_MODE;
      end else begin
        mode_q <= iopll_pkg::IOPLL_CLKOUT_MODE;
      end
    end
  end

  // register reads, data valid the cycle after the strobe

  // unmapped addresses and reserved bits read zero
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == `IOPLL_ADDR_TUNE) begin
        rdata_q <= {1'b0, pll_en_q, tune_q};
      end else if (i_addr == `IOPLL_ADDR_OSCCTL) begin
        rdata_q <= {1'b0, fsel_q, 4'h0};
      end else if (i_addr == `IOPLL_ADDR_PINCTL) begin
        rdata_q <= {3'h0, (mode_q == iopll_pkg::IOPLL_IO_MODE), oe7_q, oe6_q, lat7_q, lat6_q};
      end else if (i_addr == `IOPLL_ADDR_STATUS) begin
        // deliberately no bit for trim movement
        rdata_q <= {5'h00, i_osc_in, i_osc_out, pll_active_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      // hold read data for exactly one cycle
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;

  // clock source selection

  // multiplier allowed only at 16 or 8 MHz selections
  assign pll_ok = pll_en_q && ((fsel_q == `IOPLL_FSEL_16M) || (fsel_q == `IOPLL_FSEL_8M));

  // base frequency of the selected internal source
  always_comb begin
    case (fsel_q)
      3'h7: base_khz = `IOPLL_KHZ_16M;
      3'h6: base_khz = `IOPLL_KHZ_8M;
      3'h5: base_khz = `IOPLL_KHZ_4M;
      3'h4: base_khz = `IOPLL_KHZ_2M;
      3'h3: base_khz = `IOPLL_KHZ_1M;
      3'h2: base_khz = `IOPLL_KHZ_500K;
      3'h1: base_khz = `IOPLL_KHZ_250K;
      default: base_khz = `IOPLL_KHZ_31K;
    endcase
  end

  // multiplied or direct system clock rate
  always_comb begin
    if (pll_ok) begin
      // 8 MHz gives 32 MHz, 16 MHz gives 64 MHz
      sys_khz_d = 16'(base_khz * `IOPLL_PLL_MULT);
    end else begin
      // unmultiplied selected source
      sys_khz_d = base_khz;
    end
  end

  // registered clock state outputs
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_khz_q <= `IOPLL_KHZ_8M;
      pll_active_q <= 1'b0;
    end else begin
      sys_khz_q <= sys_khz_d;
      pll_active_q <= pll_ok;
    end
  end

  assign o_sys_khz = sys_khz_q;
  assign o_pll_active = pll_active_q;

  // trimming

  // software value is the target, the slewer walks toward it
  assign trim.target = tune_q;

  iopll_trim_slew u_slew (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .trim(trim.slew)
  );

  // high and mid oscillators share the slewing trim
  assign o_hf_trim = trim.current;
  assign o_mf_trim = trim.current;
  // low oscillator runs on its own, trim fixed at centre
  assign o_lf_trim = 6'h00;

  // oscillator pins

  // device clock over four for the clock output
  iopll_clkdiv u_div (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .o_clk_div(clk_div)
  );

  // pin drivers registered to keep outputs glitch free
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_out_q <= 1'b0;
      osc_out_oe_q <= 1'b0;
      osc_in_q <= 1'b0;
      osc_in_oe_q <= 1'b0;
    end else begin
      // osc_in_pin is port_a_bit7_pin in both modes
      osc_in_q <= lat7_q;
      osc_in_oe_q <= oe7_q;
      if (mode_q == iopll_pkg::IOPLL_CLKOUT_MODE) begin
        // clock out overrides the port latch
        osc_out_q <= clk_div;
        osc_out_oe_q <= 1'b1;
      end else begin
        // port_a_bit6_pin, no clock output
        osc_out_q <= lat6_q;
        osc_out_oe_q <= oe6_q;
      end
    end
  end

  assign o_osc_out = osc_out_q;
  assign o_osc_out_oe = osc_out_oe_q;
  assign o_osc_in = osc_in_q;
  assign o_osc_in_oe = osc_in_oe_q;

endmodule

// ---- rtl/iopll_trim_if.sv ----
interface iopll_trim_if;
  // trim value last written by software
  iopll_pkg::iopll_tune_t target;
  // trim value the oscillators currently run at
  iopll_pkg::iopll_tune_t current;
  // high in the move state, entered one cycle after current and target differ and left one cycle after they match
  logic moving;

  modport ctl (output target, input current, input moving);
  modport slew (input target, output current, output moving);
endinterface

// ---- rtl/iopll_trim_slew.sv ----
`include "iopll_cfg.svh"

module iopll_trim_slew (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  iopll_trim_if.slew trim
);

  // step pacing counter
  logic [7:0] step_cnt_q;
  // one-cycle pulse at each step time
  logic step_en;
  // slewer state
  iopll_pkg::iopll_slew_state_t state_q;
  // current trim
  iopll_pkg::iopll_tune_t cur_q;

  localparam logic [7:0] STEP_LAST = 8'(`IOPLL_STEP_CYC - 1);

  assign step_en = (step_cnt_q == STEP_LAST);

  // free-running step divider
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step_cnt_q <= 8'h00;
    end else if (step_en) begin
      step_cnt_q <= 8'h00;
    end else begin
      step_cnt_q <= step_cnt_q + 8'h01;
    end
  end

  // move one code per step toward target, no flag to software
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= iopll_pkg::IOPLL_SLEW_IDLE;
      cur_q <= 6'h00;
    end else begin
      case (state_q)
        iopll_pkg::IOPLL_SLEW_IDLE: begin
          if (cur_q != trim.target) begin
            state_q <= iopll_pkg::IOPLL_SLEW_MOVE;
          end
        end
        iopll_pkg::IOPLL_SLEW_MOVE: begin
          if (cur_q == trim.target) begin
            state_q <= iopll_pkg::IOPLL_SLEW_IDLE;
          end else if (step_en) begin
            // unsigned codes: step by one toward target
            if (cur_q < trim.target) begin
              cur_q <= cur_q + 6'h01;
            end else begin
              cur_q <= cur_q - 6'h01;
            end
          end
        end
        default: begin
          state_q <= iopll_pkg::IOPLL_SLEW_IDLE;
        end
      endcase
    end
  end

  assign trim.current = cur_q;
  assign trim.moving = (state_q == iopll_pkg::IOPLL_SLEW_MOVE);

endmodule
